/* bench/iin_oc_host.sv */
// Host model that drives the monitor's command port.
`timescale 1ns/1ps
module iin_oc_host (
    // Clock and answers.
    input wire logic clk_i,
    input wire logic [15:0] cmd_rdata_o,
    input wire logic cmd_rvalid_o,
    // Requests.
    output logic [7:0] cmd_code_i,
    output logic cmd_write_i,
    output logic cmd_read_i,
    output logic [15:0] cmd_wdata_i
);
    initial begin
        cmd_code_i = 8'h00;
        cmd_write_i = 1'b0;
        cmd_read_i = 1'b0;
        cmd_wdata_i = 16'h0000;
    end
    // Released lines show the inverse of the last value.
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        cmd_code_i = c;
        cmd_wdata_i = d;
        cmd_write_i = 1'b1;
        @(posedge clk_i);
        #1 cmd_write_i = 1'b0;
        cmd_code_i = ~c;
        cmd_wdata_i = ~d;
        @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] c, output logic [15:0] q, output logic ok);
        cmd_code_i = c;
        cmd_read_i = 1'b1;
        @(posedge clk_i);
        #1 cmd_read_i = 1'b0;
        cmd_code_i = ~c;
        ok = cmd_rvalid_o;
        q = cmd_rdata_o;
        @(posedge clk_i);
        #1;
    endtask
endmodule // iin_oc_host

/* bench/input_overcurrent_fault_monitor_asserts.sv */
// Assertions on the monitor's ports.
`timescale 1ns/1ps
module iin_oc_asserts (
    input wire logic clk_i, rst_i, cmd_write_i, cmd_read_i, measured_valid_i,
    input wire logic enable_request_i, clear_faults_i, cmd_rvalid_o, status_input_o,
    input wire logic [7:0] cmd_code_i, status_byte_o,
    input wire logic [15:0] cmd_wdata_i, measured_current_i, cmd_rdata_o,
    input wire logic input_overcurrent_fault_flag_o, input_overcurrent_warning_flag_o,
    input wire logic bus_alert_out_o, regulator_fault_out_o, output_enable_o
);
    wire logic flt = input_overcurrent_fault_flag_o;
    wire logic wrn = input_overcurrent_warning_flag_o;
    wire logic rf = regulator_fault_out_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_read_answer: assert property (1 |=> cmd_rvalid_o == $past(cmd_read_i))
        else $error("read answer strobe wrong");
    a_resp_const: assert property (cmd_read_i && cmd_code_i == 8'h5c |=>
        cmd_rdata_o == 16'h00c0)
        else $error("response byte wrong");
    a_alert_level: assert property (bus_alert_out_o == (flt | wrn))
        else $error("alert level wrong");
    a_other_bit: assert property (status_byte_o == {7'h00, flt | wrn})
        else $error("status byte wrong");
    a_input_flag: assert property (status_input_o == (flt | wrn))
        else $error("input flag wrong");
    a_pins_rise: assert property ($rose(flt) |-> rf && bus_alert_out_o)
        else $error("fault pins missing");
    a_latch_off: assert property (rf |-> !output_enable_o)
        else $error("output on while latched");
    a_stay_off: assert property (rf && !clear_faults_i |=> rf)
        else $error("latch released early");
    a_warn_only: assert property (wrn && !flt |-> !rf)
        else $error("warning latched off");
    a_enable_follow: assert property (enable_request_i ##1 !rf |-> output_enable_o)
        else $error("enable not followed");
endmodule // iin_oc_asserts
bind input_overcurrent_fault_monitor iin_oc_asserts u_chk (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .cmd_write_i(cmd_write_i),
    .cmd_read_i(cmd_read_i),
    .measured_valid_i(measured_valid_i),
    .enable_request_i(enable_request_i),
    .clear_faults_i(clear_faults_i),
    .cmd_rvalid_o(cmd_rvalid_o),
    .status_input_o(status_input_o),
    .cmd_code_i(cmd_code_i),
    .status_byte_o(status_byte_o),
    .cmd_wdata_i(cmd_wdata_i),
    .measured_current_i(measured_current_i),
    .cmd_rdata_o(cmd_rdata_o),
    .input_overcurrent_fault_flag_o(input_overcurrent_fault_flag_o),
    .input_overcurrent_warning_flag_o(input_overcurrent_warning_flag_o),
    .bus_alert_out_o(bus_alert_out_o),
    .regulator_fault_out_o(regulator_fault_out_o),
    .output_enable_o(output_enable_o)
);

/* bench/input_overcurrent_fault_monitor_tb_top.sv */
// Self-checking bench for the input overcurrent monitor.
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin mismatches++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (a), (e)); end end
module input_overcurrent_fault_monitor_tb_top;
    import iin_oc_pkg::*;
    logic clk_i = 0, rst_i = 1, measured_valid_i = 0, enable_request_i = 0, clear_faults_i = 0;
    logic cmd_write_i, cmd_read_i, cmd_rvalid_o, status_input_o, ok;
    logic input_overcurrent_fault_flag_o, input_overcurrent_warning_flag_o;
    logic bus_alert_out_o, regulator_fault_out_o, output_enable_o;
    logic [7:0] cmd_code_i, status_byte_o;
    logic [15:0] measured_current_i = 16'h0000, cmd_wdata_i, cmd_rdata_o, q;
    int mismatches = 0, n_compared = 0;
    input_overcurrent_fault_monitor dut (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cmd_code_i(cmd_code_i),
        .cmd_write_i(cmd_write_i),
        .cmd_read_i(cmd_read_i),
        .cmd_wdata_i(cmd_wdata_i),
        .cmd_rdata_o(cmd_rdata_o),
        .cmd_rvalid_o(cmd_rvalid_o),
        .measured_current_i(measured_current_i),
        .measured_valid_i(measured_valid_i),
        .enable_request_i(enable_request_i),
        .clear_faults_i(clear_faults_i),
        .status_byte_o(status_byte_o),
        .status_input_o(status_input_o),
        .input_overcurrent_fault_flag_o(input_overcurrent_fault_flag_o),
        .input_overcurrent_warning_flag_o(input_overcurrent_warning_flag_o),
        .bus_alert_out_o(bus_alert_out_o),
        .regulator_fault_out_o(regulator_fault_out_o),
        .output_enable_o(output_enable_o)
    );
    iin_oc_host host (
        .clk_i(clk_i),
        .cmd_rdata_o(cmd_rdata_o),
        .cmd_rvalid_o(cmd_rvalid_o),
        .cmd_code_i(cmd_code_i),
        .cmd_write_i(cmd_write_i),
        .cmd_read_i(cmd_read_i),
        .cmd_wdata_i(cmd_wdata_i)
    );
    initial forever #12.5 clk_i = ~clk_i;
    task automatic summarize();
        $display("Compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic rd(input logic [7:0] c, input logic [15:0] e);
        host.rd(c, q, ok);
        `CHK(ok, 1'b1)
        `CHK(q, e)
    endtask
    initial begin
        step(5);
        rst_i = 0;
        enable_request_i = 1;
        rd(CMD_FAULT_THRESHOLD, 16'h00ff);
        rd(CMD_FAULT_ACTION, 16'h00c0);
        rd(CMD_WARNING_THRESHOLD, 16'h0019);
        rd(8'h5e, 16'h0000);
        `CHK(output_enable_o, 1'b1)
        $display("Test reset_values done");
        host.wr(CMD_FAULT_ACTION, 16'h0000);
        rd(CMD_FAULT_ACTION, 16'h00c0);
        host.wr(CMD_FAULT_THRESHOLD, 16'h080a);
        host.wr(CMD_WARNING_THRESHOLD, 16'h000f);
        rd(CMD_FAULT_THRESHOLD, 16'h080a);
        rd(CMD_WARNING_THRESHOLD, 16'h000f);
        $display("Test registers done");
        measured_valid_i = 1;
        measured_current_i = 16'h0013;
        step(2);
        `CHK({input_overcurrent_warning_flag_o, input_overcurrent_fault_flag_o}, 2'b10)
        `CHK({bus_alert_out_o, status_byte_o[0], status_input_o}, 3'b111)
        `CHK({output_enable_o, regulator_fault_out_o}, 2'b10)
        $display("Test warning done");
        measured_current_i = 16'hf828;
        step(2);
        `CHK({input_overcurrent_fault_flag_o, regulator_fault_out_o}, 2'b11)
        `CHK({bus_alert_out_o, status_byte_o, status_input_o}, 10'h203)
        `CHK(output_enable_o, 1'b0)
        measured_current_i = 16'h0000;
        step(8);
        `CHK({output_enable_o, regulator_fault_out_o}, 2'b01)
        clear_faults_i = 1;
        step(1);
        clear_faults_i = 0;
        step(1);
        `CHK({input_overcurrent_fault_flag_o, regulator_fault_out_o}, 2'b00)
        `CHK(output_enable_o, 1'b1)
        $display("Test fault_latch done");
        summarize();
    end
endmodule // input_overcurrent_fault_monitor_tb_top

/* hw/iin_oc_cmp_if.sv */
// Interface between the monitor core and its threshold comparator.
`timescale 1ns/1ps
interface iin_oc_cmp_if;
    logic [15:0] measured;
    logic [15:0] fault_threshold;
    logic [15:0] warning_threshold;
    logic fault_reached;
    logic warning_reached;

    modport core (
        output measured,
        output fault_threshold,
        output warning_threshold,
        input fault_reached,
        input warning_reached
    );

    modport cmp (
        input measured,
        input fault_threshold,
        input warning_threshold,
        output fault_reached,
        output warning_reached
    );
endinterface

/* hw/iin_oc_pkg.sv */
// Constants, command codes and linear-format helpers for the input overcurrent monitor.
package iin_oc_pkg;

    // Command codes.
    localparam logic [7:0] CMD_FAULT_THRESHOLD = 8'h5b;
    localparam logic [7:0] CMD_FAULT_ACTION = 8'h5c;
    localparam logic [7:0] CMD_WARNING_THRESHOLD = 8'h5d;

    // Values after reset.
    localparam logic [15:0] FAULT_THRESHOLD_RESET = 16'h00ff;
    localparam logic [7:0] FAULT_ACTION_VALUE = 8'hc0;
    localparam logic [15:0] WARNING_THRESHOLD_RESET = 16'h0019;
    localparam logic [15:0] UNMAPPED_READ_VALUE = 16'h0000;

    // Linear word layout.
    localparam int EXP_MSB = 15;
    localparam int EXP_LSB = 11;
    localparam int MANT_MSB = 10;
    localparam int MANT_LSB = 0;
    localparam logic [5:0] EXP_BIAS = 6'h10;
    localparam int FIXED_WIDTH = 43;

    // Status bit positions.
    localparam int STATUS_OTHER_BIT = 0;

    // Converts a linear word into a signed fixed-point value scaled by two to the sixteenth.
    function automatic logic signed [FIXED_WIDTH-1:0] lin_to_fixed(input logic [15:0] word);
        logic signed [FIXED_WIDTH-1:0] mant;
        logic [5:0] shift;
        mant = FIXED_WIDTH'(signed'(word[MANT_MSB:MANT_LSB]));
        shift = {word[EXP_MSB], word[EXP_MSB:EXP_LSB]} + EXP_BIAS;
        lin_to_fixed = mant <<< shift;
    endfunction

endpackage

/* hw/iin_oc_threshold_cmp.sv */
// Compares the measured input current against both linear-format thresholds.
`timescale 1ns/1ps
module iin_oc_threshold_cmp (
    iin_oc_cmp_if.cmp cmp_if
);
    import iin_oc_pkg::*;

    logic signed [FIXED_WIDTH-1:0] meas_fixed;

    assign meas_fixed = lin_to_fixed(cmp_if.measured);
    assign cmp_if.fault_reached = meas_fixed >= lin_to_fixed(cmp_if.fault_threshold);
    assign cmp_if.warning_reached = meas_fixed >= lin_to_fixed(cmp_if.warning_threshold);

endmodule // iin_oc_threshold_cmp

/* hw/input_overcurrent_fault_monitor.sv */
// Input overcurrent fault and warning monitor with its command registers.
//
// What this block does
// - Fault threshold at 5Bh; fault when reached.
// - Thresholds: 5-bit exponent, 11-bit mantissa.
// - Fault sets other, input, fault flags, alert.
// - Fault latches controller off, no retry.
// - Fault asserts regulator fault output too.
// - Fault disables output at once, no restart.
// - Response byte 5Ch reads C0h, writes ignored.
// - Warning threshold 5Dh, default 0019h.
// - Warning sets other, input, warning flags, alert.
// - Other flag is status bit 0.
`timescale 1ns/1ps
module input_overcurrent_fault_monitor (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Command port.
    input wire logic [7:0] cmd_code_i,
    input wire logic cmd_write_i,
    input wire logic cmd_read_i,
    input wire logic [15:0] cmd_wdata_i,
    output logic [15:0] cmd_rdata_o,
    output logic cmd_rvalid_o,
    // Measurement and control.
    input wire logic [15:0] measured_current_i,
    input wire logic measured_valid_i,
    input wire logic enable_request_i,
    input wire logic clear_faults_i,
    // Status flags.
    output logic [7:0] status_byte_o,
    output logic status_input_o,
    output logic input_overcurrent_fault_flag_o,
    output logic input_overcurrent_warning_flag_o,
    // Pins and regulator control.
    output logic bus_alert_out_o,
    output logic regulator_fault_out_o,
    output logic output_enable_o
);
    import iin_oc_pkg::*;

    iin_oc_cmp_if cmp_bus ();

    iin_oc_threshold_cmp u_cmp (
        .cmp_if(cmp_bus.cmp)
    );

    logic [15:0] fault_thr_ff;
    logic [15:0] nxt_fault_thr;
    logic [15:0] warn_thr_ff;
    logic [15:0] nxt_warn_thr;
    logic fault_flag_ff;
    logic nxt_fault_flag;
    logic warn_flag_ff;
    logic nxt_warn_flag;
    logic other_ff;
    logic nxt_other;
    logic input_ff;
    logic nxt_input;
    logic latched_off_ff;
    logic nxt_latched_off;
    logic out_en_ff;
    logic nxt_out_en;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;
    logic fault_event;
    logic warn_event;
    logic wr_fault_thr;
    logic wr_warn_thr;

    assign cmp_bus.measured = measured_current_i;
    assign cmp_bus.fault_threshold = fault_thr_ff;
    assign cmp_bus.warning_threshold = warn_thr_ff;

    assign fault_event = measured_valid_i & cmp_bus.fault_reached;
    assign warn_event = measured_valid_i & cmp_bus.warning_reached;

    // only the two threshold codes take writes.
    assign wr_fault_thr = cmd_write_i & (cmd_code_i == CMD_FAULT_THRESHOLD);
    assign wr_warn_thr = cmd_write_i & (cmd_code_i == CMD_WARNING_THRESHOLD);

    // Threshold registers; the response byte has no storage.
    always_comb begin
        nxt_fault_thr = fault_thr_ff;
        nxt_warn_thr = warn_thr_ff;
        if (wr_fault_thr) begin
            nxt_fault_thr = cmd_wdata_i;
        end
        if (wr_warn_thr) begin
            nxt_warn_thr = cmd_wdata_i;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_thr_ff <= FAULT_THRESHOLD_RESET;
            warn_thr_ff <= WARNING_THRESHOLD_RESET;
        end else begin
            fault_thr_ff <= nxt_fault_thr;
            warn_thr_ff <= nxt_warn_thr;
        end
    end

    // Read data, answered one cycle after the request.
    always_comb begin
        nxt_rvalid = cmd_read_i;
        nxt_rdata = rdata_ff;
        if (cmd_read_i) begin
            unique case (cmd_code_i)
                CMD_FAULT_THRESHOLD: nxt_rdata = fault_thr_ff;
                CMD_FAULT_ACTION: nxt_rdata = {8'h00, FAULT_ACTION_VALUE};
                CMD_WARNING_THRESHOLD: nxt_rdata = warn_thr_ff;
                default: nxt_rdata = UNMAPPED_READ_VALUE;
            endcase
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_ff <= UNMAPPED_READ_VALUE;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // Sticky status flags; a new event wins over a clear in the same cycle.
    always_comb begin
        nxt_fault_flag = fault_flag_ff;
        nxt_warn_flag = warn_flag_ff;
        nxt_other = other_ff;
        nxt_input = input_ff;
        if (clear_faults_i) begin
            nxt_fault_flag = 1'b0;
            nxt_warn_flag = 1'b0;
            nxt_other = 1'b0;
            nxt_input = 1'b0;
        end
        if (fault_event) begin
            nxt_fault_flag = 1'b1;
            nxt_other = 1'b1;
            nxt_input = 1'b1;
        end
        if (warn_event) begin
            nxt_warn_flag = 1'b1;
            nxt_other = 1'b1;
            nxt_input = 1'b1;
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            fault_flag_ff <= 1'b0;
            warn_flag_ff <= 1'b0;
            other_ff <= 1'b0;
            input_ff <= 1'b0;
        end else begin
            fault_flag_ff <= nxt_fault_flag;
            warn_flag_ff <= nxt_warn_flag;
            other_ff <= nxt_other;
            input_ff <= nxt_input;
        end
    end

    // Latch-off state and output enable; warnings play no part here.
    always_comb begin
        nxt_latched_off = latched_off_ff;
        if (clear_faults_i) begin
            nxt_latched_off = 1'b0;
        end
        if (fault_event) begin
            nxt_latched_off = 1'b1;
        end
        nxt_out_en = enable_request_i & ~nxt_latched_off;
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            latched_off_ff <= 1'b0;
            out_en_ff <= 1'b0;
        end else begin
            latched_off_ff <= nxt_latched_off;
            out_en_ff <= nxt_out_en;
        end
    end

    always_comb begin
        status_byte_o = 8'h00;
        status_byte_o[STATUS_OTHER_BIT] = other_ff;
    end

    assign status_input_o = input_ff;
    assign input_overcurrent_fault_flag_o = fault_flag_ff;
    assign input_overcurrent_warning_flag_o = warn_flag_ff;
    assign bus_alert_out_o = fault_flag_ff | warn_flag_ff;
    assign regulator_fault_out_o = latched_off_ff;
    assign output_enable_o = out_en_ff;
    assign cmd_rdata_o = rdata_ff;
    assign cmd_rvalid_o = rvalid_ff;

endmodule // input_overcurrent_fault_monitor
